/* File: logic/ea_generator.sv */
`timescale 1ns/100ps
// Overview of operation
// - File direct: 13-bit field addresses low 8192 bytes.
// - File results go to file register or register 0.
// - Post-modify: pointer is address, then pointer steps.
// - Pre-modify: pointer steps first, result is address.
// - Indexed: pointer plus offset register is address.
// - Literal offset: pointer plus literal is address.
// - First operand register direct; second register/memory/5-bit literal.
// - Source and destination share one 4-bit offset field.
// - Prefetch registers 8,9 to X; 10,11 to Y.
// - Prefetch indexing only with registers 9 and 11.
// - Prefetch: indirect, indexed, post-modify by 2,4,6.
// - Branch literal 16-bit signed; interrupt hold 14-bit unsigned.
// - One X buffer (also program space), one Y.
// - Both boundaries checked, buffer works either direction.
// - Buffer length from 16-bit start and end registers.
// - Y modulo addresses keep bit zero clear.
// - X select bits 3:0, enable bit 15.
// - Y select bits 7:4, enable bit 14.
// - Boundaries checked by compare, overshoot still corrected.
// - Corrected pointer written back only for pre/post modify.
module ea_generator (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ea_req,
	input wire logic [2:0] addr_mode,
	input wire logic mac_op,
	input wire logic [1:0] space_sel,
	input wire logic [3:0] pointer_sel,
	input wire logic [15:0] pointer_value,
	input wire logic [3:0] offset_sel,
	input wire logic [15:0] offset_value,
	input wire logic [15:0] modify_value,
	input wire logic [15:0] literal_value,
	input wire logic [1:0] literal_kind,
	input wire logic [12:0] file_addr,
	input wire logic to_default_reg,
	output logic ea_valid,
	output logic [15:0] ea_addr,
	output logic [1:0] ea_space,
	output logic ea_wrapped,
	output logic wb_en,
	output logic [3:0] wb_reg_num,
	output logic [15:0] wb_value,
	output logic result_to_reg,
	output logic [3:0] result_reg_num,
	output logic [3:0] op1_reg_num,
	output logic [15:0] literal_out,
	output logic mac_error
);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic [15:0] control_reg;
	logic [15:0] x_start_reg;
	logic [15:0] x_end_reg;
	logic [15:0] y_start_reg;
	logic [15:0] y_end_reg;
	logic wrap_seen_reg;
	logic macerr_seen_reg;
	logic [15:0] last_ea_reg;
	logic wr_pend_reg;
	logic [ea_generator_pkg::ADDR_W-1:0] wr_addr_reg;
	logic hreadyout_reg;
	logic [31:0] hrdata_reg;
	logic ea_valid_reg;
	logic [15:0] ea_addr_reg;
	logic [1:0] ea_space_reg;
	logic ea_wrapped_reg;
	logic wb_en_reg;
	logic [3:0] wb_reg_num_reg;
	logic [15:0] wb_value_reg;
	logic result_to_reg_reg;
	logic [3:0] result_reg_num_reg;
	logic [3:0] op1_reg_num_reg;
	logic [15:0] literal_out_reg;
	logic mac_error_reg;

	// Bus address phase is taken only when the bus is ready and a transfer is active.
	wire addr_phase = hsel && htrans[1] && hready;
	wire [ea_generator_pkg::ADDR_W-1:0] rd_addr = haddr[ea_generator_pkg::ADDR_W-1:0];
	wire wr_ctl = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_CONTROL;
	wire wr_xs = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_X_START;
	wire wr_xe = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_X_END;
	wire wr_ys = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_Y_START;
	wire wr_ye = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_Y_END;
	wire wr_st = wr_pend_reg && wr_addr_reg == ea_generator_pkg::ADDR_STATUS;

	// Next register values; reads use them so a read right after a write sees the new data.
	// Boundary registers force bit zero so buffers always span whole words.
	wire [15:0] control_next = wr_ctl ? hwdata[15:0] : control_reg;
	wire [15:0] x_start_next = wr_xs ? {hwdata[15:1], 1'b0} : x_start_reg;
	wire [15:0] x_end_next = wr_xe ? {hwdata[15:1], 1'b1} : x_end_reg;
	wire [15:0] y_start_next = wr_ys ? {hwdata[15:1], 1'b0} : y_start_reg;
	wire [15:0] y_end_next = wr_ye ? {hwdata[15:1], 1'b1} : y_end_reg;

	// Control fields.
	wire [3:0] x_sel = control_reg[ea_generator_pkg::X_SEL_LSB +: 4];
	wire [3:0] y_sel = control_reg[ea_generator_pkg::Y_SEL_LSB +: 4];
	wire x_mod_on = control_reg[ea_generator_pkg::X_ENABLE_BIT] &&
		x_sel != ea_generator_pkg::SEL_NONE;
	wire y_mod_on = control_reg[ea_generator_pkg::Y_ENABLE_BIT] &&
		y_sel != ea_generator_pkg::SEL_NONE;

	// Prefetch routing: the register pair decides the address space.
	wire mac_x = pointer_sel[3:1] == ea_generator_pkg::MAC_X_PAIR;
	wire mac_y = pointer_sel[3:1] == ea_generator_pkg::MAC_Y_PAIR;
	wire step_ok = modify_value == ea_generator_pkg::STEP_2 ||
		modify_value == ea_generator_pkg::STEP_4 ||
		modify_value == ea_generator_pkg::STEP_6 ||
		modify_value == -ea_generator_pkg::STEP_2 ||
		modify_value == -ea_generator_pkg::STEP_4 ||
		modify_value == -ea_generator_pkg::STEP_6;
	ea_generator_pkg::addr_mode_t req_mode;
	assign req_mode = ea_generator_pkg::addr_mode_t'(addr_mode);

	// A prefetch request outside the allowed set is flagged and falls back to plain indirect.
	// Falling back keeps the pointer intact rather than guessing at the intended step.
	wire mac_mode_ok = req_mode == ea_generator_pkg::MODE_INDIRECT ||
		(req_mode == ea_generator_pkg::MODE_INDEXED && pointer_sel[0]) ||
		(req_mode == ea_generator_pkg::MODE_POST && step_ok);
	wire mac_bad = mac_op && !((mac_x || mac_y) && mac_mode_ok);
	ea_generator_pkg::addr_mode_t eff_mode;
	assign eff_mode = mac_bad ? ea_generator_pkg::MODE_INDIRECT : req_mode;
	wire [1:0] eff_space = mac_op ? (mac_y ? 2'(ea_generator_pkg::SPACE_Y) :
		2'(ea_generator_pkg::SPACE_X_READ)) : space_sel;
	wire is_y = eff_space == 2'(ea_generator_pkg::SPACE_Y);

	// Raw sums for each indirect form.
	wire [15:0] step_sum = pointer_value + modify_value;
	wire [15:0] index_sum = pointer_value + offset_value;
	wire [15:0] lit_sum = pointer_value + literal_value;
	wire is_file = eff_mode == ea_generator_pkg::MODE_FILE;
	wire is_pre = eff_mode == ea_generator_pkg::MODE_PRE;
	wire is_post = eff_mode == ea_generator_pkg::MODE_POST;
	wire is_ptr = eff_mode == ea_generator_pkg::MODE_INDIRECT || is_pre || is_post ||
		eff_mode == ea_generator_pkg::MODE_INDEXED ||
		eff_mode == ea_generator_pkg::MODE_LIT_OFFSET;

	// The value the corrector sees: the stepped pointer for pre/post, else the address.
	wire [15:0] target = (is_pre || is_post) ? step_sum :
		eff_mode == ea_generator_pkg::MODE_INDEXED ? index_sum :
		eff_mode == ea_generator_pkg::MODE_LIT_OFFSET ? lit_sum : pointer_value;

	// X and program space share one buffer; Y has its own.
	wire mod_apply = is_ptr && (is_y ? (y_mod_on && pointer_sel == y_sel) :
		(x_mod_on && pointer_sel == x_sel));
	wire [15:0] buf_start = is_y ? y_start_reg : x_start_reg;
	wire [15:0] buf_end = is_y ? y_end_reg : x_end_reg;
	wire [16:0] buf_len = 17'(buf_end) - 17'(buf_start) + 17'h0_0001;

	// Both limits are compared every time, so a step past either edge is folded back.
	// A step larger than the buffer length is folded only once; software must keep steps short.
	wire above = target > buf_end;
	wire below = target < buf_start;
	wire [15:0] folded = above ? 16'(17'(target) - buf_len) :
		below ? 16'(17'(target) + buf_len) : target;
	wire do_wrap = mod_apply && (above || below);
	wire [15:0] corrected = do_wrap ? folded : target;
	wire [15:0] y_mask = is_y ? 16'hfffe : 16'hffff;

	// Address for each mode; post-modify presents the old pointer.
	wire [15:0] ea_value = is_file ? {3'b000, file_addr} :
		is_post ? pointer_value : corrected;
	wire [15:0] ea_final = ea_value & y_mask;
	wire [15:0] wb_final = corrected & y_mask;
	wire ea_has_addr = is_file || is_ptr;

	// Literal widths by kind.
	wire [15:0] lit_shaped = literal_kind == 2'(ea_generator_pkg::LIT_HOLD) ?
		{2'b00, literal_value[13:0]} :
		literal_kind == 2'(ea_generator_pkg::LIT_SHORT) ?
		{11'h000, literal_value[4:0]} : literal_value;

	// Status read value: last address and the two sticky flags.
	wire [31:0] status_word = {14'h0000, macerr_seen_reg, wrap_seen_reg, last_ea_reg};

	// Read mux, addressed in the address phase so data is ready in the data phase.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_addr == ea_generator_pkg::ADDR_CONTROL) begin
			rd_mux = {16'h0000, control_next};
		end else if (rd_addr == ea_generator_pkg::ADDR_X_START) begin
			rd_mux = {16'h0000, x_start_next};
		end else if (rd_addr == ea_generator_pkg::ADDR_X_END) begin
			rd_mux = {16'h0000, x_end_next};
		end else if (rd_addr == ea_generator_pkg::ADDR_Y_START) begin
			rd_mux = {16'h0000, y_start_next};
		end else if (rd_addr == ea_generator_pkg::ADDR_Y_END) begin
			rd_mux = {16'h0000, y_end_next};
		end else if (rd_addr == ea_generator_pkg::ADDR_STATUS) begin
			rd_mux = status_word;
		end
	end

	// Bus slave: zero wait state, always OKAY, unmapped reads return zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= rd_addr;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Configuration registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_reg <= ea_generator_pkg::CONTROL_RESET;
			x_start_reg <= ea_generator_pkg::START_RESET;
			x_end_reg <= ea_generator_pkg::END_RESET;
			y_start_reg <= ea_generator_pkg::START_RESET;
			y_end_reg <= ea_generator_pkg::END_RESET;
		end else begin
			control_reg <= control_next;
			x_start_reg <= x_start_next;
			x_end_reg <= x_end_next;
			y_start_reg <= y_start_next;
			y_end_reg <= y_end_next;
		end
	end

	// Sticky flags clear on a written one, but a new event in the same cycle wins.
	wire new_wrap = ea_req && do_wrap;
	wire new_macerr = ea_req && mac_bad;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wrap_seen_reg <= 1'b0;
			macerr_seen_reg <= 1'b0;
			last_ea_reg <= 16'h0000;
		end else begin
			wrap_seen_reg <= new_wrap ||
				(wrap_seen_reg && !(wr_st && hwdata[ea_generator_pkg::STAT_WRAP_BIT]));
			macerr_seen_reg <= new_macerr ||
				(macerr_seen_reg && !(wr_st && hwdata[ea_generator_pkg::STAT_MACERR_BIT]));
			last_ea_reg <= (ea_req && ea_has_addr) ? ea_final : last_ea_reg;
		end
	end

	// Result stage: every request is answered one cycle later.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ea_valid_reg <= 1'b0;
			ea_addr_reg <= 16'h0000;
			ea_space_reg <= 2'b00;
			ea_wrapped_reg <= 1'b0;
			wb_en_reg <= 1'b0;
			wb_reg_num_reg <= 4'h0;
			wb_value_reg <= 16'h0000;
			result_to_reg_reg <= 1'b0;
			result_reg_num_reg <= 4'h0;
			op1_reg_num_reg <= 4'h0;
			literal_out_reg <= 16'h0000;
			mac_error_reg <= 1'b0;
		end else begin
			ea_valid_reg <= ea_req && ea_has_addr;
			ea_addr_reg <= ea_final;
			ea_space_reg <= eff_space;
			ea_wrapped_reg <= new_wrap;
			wb_en_reg <= ea_req && (is_pre || is_post);
			wb_reg_num_reg <= pointer_sel;
			wb_value_reg <= wb_final;
			result_to_reg_reg <= ea_req && is_file && to_default_reg;
			result_reg_num_reg <= ea_generator_pkg::DEFAULT_REG_NUM;
			op1_reg_num_reg <= offset_sel;
			literal_out_reg <= lit_shaped;
			mac_error_reg <= new_macerr;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign ea_valid = ea_valid_reg;
	assign ea_addr = ea_addr_reg;
	assign ea_space = ea_space_reg;
	assign ea_wrapped = ea_wrapped_reg;
	assign wb_en = wb_en_reg;
	assign wb_reg_num = wb_reg_num_reg;
	assign wb_value = wb_value_reg;
	assign result_to_reg = result_to_reg_reg;
	assign result_reg_num = result_reg_num_reg;
	assign op1_reg_num = op1_reg_num_reg;
	assign literal_out = literal_out_reg;
	assign mac_error = mac_error_reg;

	// Checks on the address path; folds are checked against start and end, not the length.
	AST_FILE_ADDR: assert property (ea_req && !mac_op &&
		addr_mode == 3'(ea_generator_pkg::MODE_FILE)
		|=> ea_valid && ea_addr == {3'b000, $past(file_addr)})
		else $error("File address not passed through.");
	AST_DEFAULT_REG: assert property (ea_req && !mac_op && to_default_reg &&
		addr_mode == 3'(ea_generator_pkg::MODE_FILE) |=> result_to_reg && result_reg_num == 4'h0)
		else $error("File result not steered to register zero.");
	AST_POST_OLD: assert property (ea_req && !mac_op &&
		space_sel != 2'(ea_generator_pkg::SPACE_Y) &&
		addr_mode == 3'(ea_generator_pkg::MODE_POST) |=> ea_addr == $past(pointer_value) && wb_en)
		else $error("Post-modify address is not the old pointer.");
	AST_PRE_SAME: assert property (ea_req && !mac_op &&
		addr_mode == 3'(ea_generator_pkg::MODE_PRE) |=> wb_en && wb_value == ea_addr)
		else $error("Pre-modify write-back differs from address.");
	AST_PRE_STEP: assert property (ea_req && is_pre && !mod_apply && !is_y
		|=> ea_addr == $past(16'(pointer_value + modify_value)))
		else $error("Pre-modify address is not pointer plus step.");
	AST_INDEX_SUM: assert property (ea_req && !mac_op && !mod_apply && !is_y &&
		addr_mode == 3'(ea_generator_pkg::MODE_INDEXED) |=> ea_addr == $past(index_sum))
		else $error("Indexed address is not pointer plus offset.");
	AST_LIT_SUM: assert property (ea_req && !mac_op && !mod_apply && !is_y &&
		addr_mode == 3'(ea_generator_pkg::MODE_LIT_OFFSET)
		|=> ea_addr == $past(16'(pointer_value + literal_value)))
		else $error("Literal offset address is not pointer plus literal.");
	AST_OFFSET_NO_WB: assert property (ea_req &&
		(addr_mode == 3'(ea_generator_pkg::MODE_INDEXED) ||
		addr_mode == 3'(ea_generator_pkg::MODE_LIT_OFFSET)) |=> !wb_en)
		else $error("Offset mode wrote the pointer back.");
	AST_WB_TARGET: assert property (ea_req && (is_pre || is_post)
		|=> wb_en && wb_reg_num == $past(pointer_sel))
		else $error("Modified pointer not written back to its own register.");
	AST_MAC_Y_ROUTE: assert property (ea_req && mac_op &&
		pointer_sel[3:1] == ea_generator_pkg::MAC_Y_PAIR
		|=> ea_space == 2'(ea_generator_pkg::SPACE_Y))
		else $error("Prefetch register 10 or 11 not routed to Y.");
	AST_MAC_X_ROUTE: assert property (ea_req && mac_op &&
		pointer_sel[3:1] == ea_generator_pkg::MAC_X_PAIR
		|=> ea_space == 2'(ea_generator_pkg::SPACE_X_READ))
		else $error("Prefetch register 8 or 9 not routed to X.");
	AST_MAC_INDEX: assert property (ea_req && mac_op && !pointer_sel[0] &&
		addr_mode == 3'(ea_generator_pkg::MODE_INDEXED) |=> mac_error && !wb_en)
		else $error("Indexed prefetch on even register not refused.");
	AST_HOLD_LIT: assert property (ea_req && literal_kind == 2'(ea_generator_pkg::LIT_HOLD)
		|=> literal_out[15:14] == 2'b00 && literal_out[13:0] == $past(literal_value[13:0]))
		else $error("Interrupt hold literal not fourteen bits.");
	AST_Y_WORD: assert property (ea_valid && ea_space == 2'(ea_generator_pkg::SPACE_Y)
		|-> !ea_addr[0])
		else $error("Y address has bit zero set.");
	AST_X_OFF: assert property (ea_req && !is_y && (x_sel == 4'hf ||
		!control_reg[ea_generator_pkg::X_ENABLE_BIT]) |=> !ea_wrapped)
		else $error("X correction applied while disabled.");
	AST_OTHER_PTR: assert property (ea_req &&
		(is_y ? pointer_sel != y_sel : pointer_sel != x_sel) |=> !ea_wrapped)
		else $error("Correction applied to an unselected pointer.");
	AST_WRAP_INSIDE: assert property (ea_wrapped && wb_en && $stable(x_start_reg) &&
		ea_space != 2'(ea_generator_pkg::SPACE_Y) |-> wb_value >= x_start_reg)
		else $error("Wrapped pointer fell below buffer start.");
	AST_FOLD_UP: assert property (ea_req && (is_pre || is_post) && mod_apply && !is_y &&
		target > x_end_reg |=> ea_wrapped &&
		wb_value == 16'($past(x_start_reg + target - x_end_reg) - 16'h0001))
		else $error("Pointer past the end not folded to start plus overshoot.");
	AST_FOLD_DOWN: assert property (ea_req && (is_pre || is_post) && mod_apply && !is_y &&
		target < x_start_reg |=> ea_wrapped &&
		wb_value == 16'($past(x_end_reg + target - x_start_reg) + 16'h0001))
		else $error("Pointer below the start not folded to end minus undershoot.");
	AST_Y_FOLD: assert property (ea_req && is_post && is_y && mod_apply && !target[0] &&
		target > y_end_reg |=> ea_wrapped &&
		wb_value == 16'($past(y_start_reg + target - y_end_reg) - 16'h0001))
		else $error("Y pointer not folded inside its own buffer.");

endmodule : ea_generator

/* File: logic/ea_generator_pkg.sv */
package ea_generator_pkg;

	// Register indices as printed; the bus byte address is four times the index.
	localparam logic [7:0] IDX_CONTROL = 8'h46;
	localparam logic [7:0] IDX_X_START = 8'h48;
	localparam logic [7:0] IDX_X_END = 8'h4a;
	localparam logic [7:0] IDX_Y_START = 8'h4c;
	localparam logic [7:0] IDX_Y_END = 8'h4e;
	localparam logic [7:0] IDX_STATUS = 8'h54;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CONTROL = 12'h118;
	localparam logic [11:0] ADDR_X_START = 12'h120;
	localparam logic [11:0] ADDR_X_END = 12'h128;
	localparam logic [11:0] ADDR_Y_START = 12'h130;
	localparam logic [11:0] ADDR_Y_END = 12'h138;
	localparam logic [11:0] ADDR_STATUS = 12'h150;

	// Field positions inside the control word.
	localparam int X_SEL_LSB = 0;
	localparam int Y_SEL_LSB = 4;
	localparam int X_ENABLE_BIT = 15;
	localparam int Y_ENABLE_BIT = 14;
	localparam logic [3:0] SEL_NONE = 4'hf;

	// Status word layout: last address below, sticky flags above.
	localparam int STAT_WRAP_BIT = 16;
	localparam int STAT_MACERR_BIT = 17;

	// Values after reset.
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] START_RESET = 16'h0000;
	localparam logic [15:0] END_RESET = 16'h0001;

	// Fixed register numbers.
	localparam logic [3:0] DEFAULT_REG_NUM = 4'h0;
	localparam logic [2:0] MAC_X_PAIR = 3'h4;
	localparam logic [2:0] MAC_Y_PAIR = 3'h5;
	localparam int FILE_ADDR_W = 13;

	// Legal post-modify steps of the prefetch pointers.
	localparam logic [15:0] STEP_2 = 16'h0002;
	localparam logic [15:0] STEP_4 = 16'h0004;
	localparam logic [15:0] STEP_6 = 16'h0006;

	typedef enum logic [2:0] {
		MODE_FILE,
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_POST,
		MODE_PRE,
		MODE_INDEXED,
		MODE_LIT_OFFSET,
		MODE_LITERAL
	} addr_mode_t;

	typedef enum logic [1:0] {
		SPACE_X_READ,
		SPACE_X_WRITE,
		SPACE_Y,
		SPACE_PROGRAM
	} space_t;

	typedef enum logic [1:0] {
		LIT_BRANCH,
		LIT_HOLD,
		LIT_SHORT
	} literal_kind_t;

endpackage : ea_generator_pkg

/* File: testbench/core_regs_model.sv */
`timescale 1ns/100ps
// Working register file that stands in for the decoder side of the core.
module core_regs_model (
	input wire logic hclk,
	input wire logic load_en,
	input wire logic [3:0] load_num,
	input wire logic [15:0] load_value,
	input wire logic wb_en,
	input wire logic [3:0] wb_reg_num,
	input wire logic [15:0] wb_value,
	input wire logic [3:0] pointer_sel,
	input wire logic [3:0] offset_sel,
	output logic [15:0] pointer_value,
	output logic [15:0] offset_value
);
	logic [15:0] regs [16];

	// Both operands are read straight from the file, as the decoder presents them.
	assign pointer_value = regs[pointer_sel];
	assign offset_value = regs[offset_sel];

	// Write-back wins over a preload, since a lost pointer update would hide a wrap fault.
	always_ff @(posedge hclk) begin
		if (wb_en) begin
			regs[wb_reg_num] <= wb_value;
		end else if (load_en) begin
			regs[load_num] <= load_value;
		end
	end
endmodule : core_regs_model

/* File: testbench/test_ea_generator.sv */
`timescale 1ns/100ps
module test_ea_generator;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, d;
	logic [1:0] htrans = 2'b00, space_sel = 2'b00, literal_kind = 2'b00, ea_space;
	logic [2:0] hsize = 3'b010, addr_mode = 3'b000;
	logic hreadyout, hresp, ea_valid, ea_wrapped, wb_en, result_to_reg, mac_error;
	logic ea_req = 1'b0, mac_op = 1'b0, to_default_reg = 1'b0, load_en = 1'b0;
	logic [3:0] pointer_sel = 4'h0, offset_sel = 4'h0, load_num = 4'h0;
	logic [3:0] wb_reg_num, result_reg_num, op1_reg_num;
	logic [15:0] modify_value = 16'h0000, literal_value = 16'h0000, load_value = 16'h0000;
	logic [15:0] pointer_value, offset_value, ea_addr, wb_value, literal_out;
	logic [12:0] file_addr = 13'h0000;
	logic [15:0] lit_exp [3] = '{16'hb5a5, 16'h35a5, 16'h0005};
	int bad_count = 0;
	int tests_run = 0;

	// The bus is a single slave, so its own ready closes the loop.
	ea_generator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ea_req(ea_req), .addr_mode(addr_mode), .mac_op(mac_op), .space_sel(space_sel),
		.pointer_sel(pointer_sel), .pointer_value(pointer_value), .offset_sel(offset_sel),
		.offset_value(offset_value), .modify_value(modify_value),
		.literal_value(literal_value), .literal_kind(literal_kind), .file_addr(file_addr),
		.to_default_reg(to_default_reg), .ea_valid(ea_valid), .ea_addr(ea_addr),
		.ea_space(ea_space), .ea_wrapped(ea_wrapped), .wb_en(wb_en),
		.wb_reg_num(wb_reg_num), .wb_value(wb_value), .result_to_reg(result_to_reg),
		.result_reg_num(result_reg_num), .op1_reg_num(op1_reg_num),
		.literal_out(literal_out), .mac_error(mac_error));

	// The register file feeds pointer contents back, including written-back values.
	core_regs_model partner (.hclk(hclk), .load_en(load_en), .load_num(load_num),
		.load_value(load_value), .wb_en(wb_en), .wb_reg_num(wb_reg_num),
		.wb_value(wb_value), .pointer_sel(pointer_sel), .offset_sel(offset_sel),
		.pointer_value(pointer_value), .offset_value(offset_value));

	// A 4 ns period gives the 250 MHz core clock.
	always #2 hclk = ~hclk;

	task check(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	// Waits for ready at a rising edge; a stuck bus ends the run.
	task wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				report_and_stop;
			end
			@(posedge hclk);
		end
	endtask : wait_ready

	task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask : bus

	task wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] dummy;
		bus(1'b1, a, v, dummy);
	endtask : wr

	task load(input logic [3:0] n, input logic [15:0] v);
		@(posedge hclk);
		load_en <= 1'b1;
		load_num <= n;
		load_value <= v;
		@(posedge hclk);
		load_en <= 1'b0;
	endtask : load

	// One request pulse; results are looked at in the single cycle that they stand.
	task request(input logic [2:0] m, input logic mac, input logic [1:0] sp,
		input logic [3:0] ps, input logic [3:0] os, input logic [15:0] md,
		input logic [15:0] lit);
		@(posedge hclk);
		ea_req <= 1'b1;
		addr_mode <= m;
		mac_op <= mac;
		space_sel <= sp;
		pointer_sel <= ps;
		offset_sel <= os;
		modify_value <= md;
		literal_value <= lit;
		@(posedge hclk);
		ea_req <= 1'b0;
		#1;
	endtask : request

	// Main sequence: reset values, linear modes, literals, then both circular buffers.
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, ea_generator_pkg::ADDR_CONTROL, 32'h0, d);
		check(d, {16'h0000, ea_generator_pkg::CONTROL_RESET});
		bus(1'b0, ea_generator_pkg::ADDR_X_END, 32'h0, d);
		check(d, {16'h0000, ea_generator_pkg::END_RESET});
		bus(1'b0, 12'h200, 32'h0, d);
		check(d, 32'h0000_0000);
		file_addr <= 13'h1fff;
		to_default_reg <= 1'b1;
		request(ea_generator_pkg::MODE_FILE, 0, 0, 0, 0, 0, 0);
		check({ea_valid, ea_addr}, 32'h0001_1fff);
		check({result_to_reg, result_reg_num}, 32'h0000_0010);
		load(4'h3, 16'h0100);
		load(4'h5, 16'h0030);
		request(ea_generator_pkg::MODE_POST, 0, 0, 3, 5, 16'h0002, 0);
		check({wb_en, wb_value, ea_addr}, 33'h1_0102_0100);
		check(op1_reg_num, 32'h0000_0005);
		request(ea_generator_pkg::MODE_PRE, 0, 0, 3, 5, 16'hfffe, 0);
		check({wb_en, wb_value, ea_addr}, 33'h1_0100_0100);
		request(ea_generator_pkg::MODE_INDEXED, 0, 0, 3, 5, 0, 0);
		check({wb_en, ea_addr}, 32'h0000_0130);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 0, 3, 5, 0, 16'h0008);
		check(ea_addr, 32'h0000_0108);
		request(ea_generator_pkg::MODE_DIRECT, 0, 0, 3, 5, 0, 0);
		check({ea_valid, wb_en, ea_wrapped}, 3'b000);
		for (int k = 0; k < 3; k++) begin
			@(posedge hclk) literal_kind <= 2'(k);
			request(ea_generator_pkg::MODE_LITERAL, 0, 0, 0, 0, 0, 16'hb5a5);
			check(literal_out, lit_exp[k]);
		end
		// Pointer 2 is the buffer pointer; pointer 3 stays out of it.
		wr(ea_generator_pkg::ADDR_X_START, 32'h0000_1000);
		wr(ea_generator_pkg::ADDR_X_END, 32'h0000_101f);
		wr(ea_generator_pkg::ADDR_CONTROL, 32'h0000_80f2);
		bus(1'b0, ea_generator_pkg::ADDR_CONTROL, 32'h0, d);
		check(d, 32'h0000_80f2);
		load(4'h2, 16'h101e);
		load(4'h3, 16'h101e);
		request(ea_generator_pkg::MODE_POST, 0, 0, 2, 0, 16'h0004, 0);
		check({ea_wrapped, wb_value, ea_addr}, 33'h1_1002_101e);
		check({hresp, wb_reg_num}, 5'h02);
		request(ea_generator_pkg::MODE_PRE, 0, 0, 2, 0, 16'hfffc, 0);
		check({ea_wrapped, wb_value, ea_addr}, 33'h1_101e_101e);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 0, 2, 0, 0, 16'h0004);
		check({wb_en, ea_addr}, 32'h0000_1002);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 3, 2, 0, 0, 16'h0004);
		check(ea_addr, 32'h0000_1002);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 0, 3, 0, 0, 16'h0004);
		check({ea_wrapped, ea_addr}, 32'h0000_1022);
		bus(1'b0, ea_generator_pkg::ADDR_STATUS, 32'h0, d);
		check(d[16], 32'h0000_0001);
		wr(ea_generator_pkg::ADDR_STATUS, 32'h0001_0000);
		bus(1'b0, ea_generator_pkg::ADDR_STATUS, 32'h0, d);
		check(d[16], 32'h0000_0000);
		wr(ea_generator_pkg::ADDR_CONTROL, 32'h0000_80ff);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 0, 2, 0, 0, 16'h0004);
		check(ea_addr, 32'h0000_1022);
		wr(ea_generator_pkg::ADDR_CONTROL, 32'h0000_00f2);
		request(ea_generator_pkg::MODE_LIT_OFFSET, 0, 0, 2, 0, 0, 16'h0004);
		check(ea_addr, 32'h0000_1022);
		// Y buffer on pointer 10, sixteen bytes long.
		wr(ea_generator_pkg::ADDR_Y_START, 32'h0000_2000);
		wr(ea_generator_pkg::ADDR_Y_END, 32'h0000_200f);
		wr(ea_generator_pkg::ADDR_CONTROL, 32'h0000_40af);
		bus(1'b0, ea_generator_pkg::ADDR_CONTROL, 32'h0, d);
		check(d, 32'h0000_40af);
		load(4'ha, 16'h200c);
		request(ea_generator_pkg::MODE_POST, 1, 0, 10, 0, 16'h0006, 0);
		check({mac_error, wb_value, ea_addr}, 32'h2002_200c);
		check(ea_space, ea_generator_pkg::SPACE_Y);
		load(4'h4, 16'h2001);
		request(ea_generator_pkg::MODE_INDIRECT, 0, 2, 4, 0, 0, 0);
		check(ea_addr, 32'h0000_2000);
		load(4'h8, 16'h0200);
		load(4'h9, 16'h0300);
		request(ea_generator_pkg::MODE_INDIRECT, 1, 2, 8, 0, 0, 0);
		check(ea_space, ea_generator_pkg::SPACE_X_READ);
		request(ea_generator_pkg::MODE_INDEXED, 1, 0, 8, 5, 0, 0);
		check({mac_error, ea_addr}, 32'h0001_0200);
		request(ea_generator_pkg::MODE_INDEXED, 1, 0, 9, 5, 0, 0);
		check({mac_error, ea_addr}, 32'h0000_0330);
		request(ea_generator_pkg::MODE_POST, 1, 0, 8, 0, 16'h0008, 0);
		check(mac_error, 32'h0000_0001);
		bus(1'b0, ea_generator_pkg::ADDR_STATUS, 32'h0, d);
		check(d, 32'h0003_0200);
		report_and_stop;
	end
endmodule : test_ea_generator
